// ### rtl/sap_ctrl.sv
// serial read-out and power-mode control of a successive approximation converter
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`include "sap_defs.svh"
module sap_ctrl #(
  parameter int res_bits = 12
) (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                select_n,
  input  wire logic                serial_clk,
  input  wire logic [res_bits-1:0] conv_result,
  output logic                     serial_result_out,
  output logic                     serial_result_oe_n,
  output logic                     track_hold,
  output logic                     conv_start,
  output logic                     powered_down,
  output logic                     result_lsb
);
  // ----------------------------------------------------------------------------
  // checks and synchronisers
  // ----------------------------------------------------------------------------
  initial begin
    if (res_bits != 12 && res_bits != 10) $error("res_bits must be 12 or 10");
    if (`SAP_DISABLE_CYCLES < 1) $error("disable delay under one cycle");
  end

  logic sel_s;
  logic sck_s;
  logic sel_d;
  logic sck_d;

  sap_sync #(.init(1'b1)) u_sel (
    .clock  (clock),
    .rst_n  (rst_n),
    .pin    (select_n),
    .synced (sel_s)
  );

  sap_sync #(.init(1'b0)) u_sck (
    .clock  (clock),
    .rst_n  (rst_n),
    .pin    (serial_clk),
    .synced (sck_s)
  );

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sel_d <= 1'b1;
      sck_d <= 1'b0;
    end else begin
      sel_d <= sel_s;
      sck_d <= sck_s;
    end
  end

  logic sel_fall;
  logic sel_rise;
  logic sck_fall;
  logic sck_rise;
  assign sel_fall = sel_d & ~sel_s;
  assign sel_rise = ~sel_d & sel_s;
  assign sck_fall = sck_d & ~sck_s;
  assign sck_rise = ~sck_d & sck_s;

  // ----------------------------------------------------------------------------
  // frame sequencing
  // ----------------------------------------------------------------------------
  sap_pkg::sap_state_t            state;
  logic [`SAP_CNT_W-1:0]          edges;
  logic                           track_due;
  logic                           shift_bit;
  logic                           frame_active;
  logic                           sel_rise_early;
  logic                           sel_rise_pdn;

  assign frame_active = (state == sap_pkg::SAP_CONVERT);
  // the last bit is launched on edge 15; edge 16 only ends the frame
  assign shift_bit = frame_active & sck_fall & !sel_rise
                   & (edges < `SAP_CNT_W'(`SAP_FRAME_BITS - 1));

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= sap_pkg::SAP_IDLE;
    end else begin
      unique case (state)
        sap_pkg::SAP_IDLE: begin
          if (sel_fall) begin
            state <= sap_pkg::SAP_CONVERT;
          end
        end
        sap_pkg::SAP_CONVERT: begin
          if (sel_rise) begin
            state <= sap_pkg::SAP_IDLE;
          end else if (sck_fall && edges == `SAP_CNT_W'(`SAP_FRAME_BITS - 1)) begin
            state <= sap_pkg::SAP_DONE;
          end
        end
        sap_pkg::SAP_DONE: begin
          // select may idle low here; only a rise rearms
          if (sel_rise) begin
            state <= sap_pkg::SAP_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      edges <= '0;
    end else if (state == sap_pkg::SAP_IDLE) begin
      edges <= '0;
    end else if (frame_active && sck_fall) begin
      edges <= edges + `SAP_CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------------------
  // track and hold, conversion start
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      track_due <= 1'b0;
    end else if (!frame_active) begin
      track_due <= 1'b0;
    end else if (sck_fall && edges == `SAP_CNT_W'(`SAP_TRACK_EDGE - 1)) begin
      track_due <= 1'b1;
    end
  end

  // power-on state tracks, as after supplies come up
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      track_hold <= 1'b1;
    end else if (state == sap_pkg::SAP_IDLE && sel_fall) begin
      track_hold <= 1'b0;
    end else if (frame_active && sel_rise) begin
      // hold while asleep, including the frame that puts the device to sleep
      track_hold <= !(sel_rise_pdn || powered_down);
    end else if (frame_active && powered_down && (sck_rise || sck_fall)) begin
      track_hold <= 1'b1;
    end else if (frame_active && track_due && sck_rise) begin
      track_hold <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= (state == sap_pkg::SAP_IDLE) && sel_fall;
    end
  end

  // ----------------------------------------------------------------------------
  // power mode
  // ----------------------------------------------------------------------------
  assign sel_rise_early = frame_active & sel_rise
                        & (edges < `SAP_CNT_W'(`SAP_PDN_LOW_EDGE));
  assign sel_rise_pdn   = frame_active & sel_rise
                        & (edges >= `SAP_CNT_W'(`SAP_PDN_LOW_EDGE))
                        & (edges < `SAP_CNT_W'(`SAP_PDN_HIGH_EDGE));

  // the mode flag means "was asleep at frame start"; analog power-up begins at the
  // fall but the mode only commits once edge 10 passes with select still low
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      powered_down <= 1'b0;
    end else if (sel_rise_pdn) begin
      powered_down <= 1'b1;
    end else if (frame_active && sck_fall && !sel_rise
                 && edges == `SAP_CNT_W'(`SAP_PDN_HIGH_EDGE - 1)) begin
      powered_down <= 1'b0;
    end else if (sel_rise_early) begin
      powered_down <= powered_down;
    end
  end

  // ----------------------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------------------
  logic bit_now;

  sap_shift #(.res_bits(res_bits)) u_shift (
    .clock   (clock),
    .rst_n   (rst_n),
    .load    (state == sap_pkg::SAP_IDLE && sel_fall),
    .shift   (shift_bit),
    .result  (conv_result),
    .bit_out (bit_now)
  );

  // driven one cycle behind the decision, well within the disable delay
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      serial_result_oe_n <= 1'b1;
    end else if (state == sap_pkg::SAP_IDLE && sel_fall) begin
      serial_result_oe_n <= 1'b0;
    end else if (frame_active && (sel_rise || (sck_fall && !shift_bit))) begin
      serial_result_oe_n <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      serial_result_out <= 1'b0;
    end else begin
      serial_result_out <= (frame_active || state == sap_pkg::SAP_DONE) ? bit_now : 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      result_lsb <= 1'b0;
    end else if (state == sap_pkg::SAP_IDLE && sel_fall) begin
      result_lsb <= conv_result[0];
    end
  end

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  chk_oe_on_fall: assert property (@(posedge clock) disable iff (!rst_n)
    (state == sap_pkg::SAP_IDLE && sel_fall) |=> !serial_result_oe_n && !track_hold)
    else $error("output not driven after select fall");

  chk_release_16: assert property (@(posedge clock) disable iff (!rst_n)
    (frame_active && sck_fall && !sel_rise && edges == `SAP_CNT_W'(`SAP_FRAME_BITS - 1))
      |=> serial_result_oe_n && state == sap_pkg::SAP_DONE)
    else $error("output not released on edge 16");

  chk_abort_rise: assert property (@(posedge clock) disable iff (!rst_n)
    (frame_active && sel_rise) |=> serial_result_oe_n && state == sap_pkg::SAP_IDLE)
    else $error("early rise did not abort");

  chk_pdn_window: assert property (@(posedge clock) disable iff (!rst_n)
    sel_rise_pdn |=> powered_down)
    else $error("no power-down in window");

  chk_no_pdn_early: assert property (@(posedge clock) disable iff (!rst_n)
    (sel_rise_early && !powered_down) |=> !powered_down)
    else $error("power-down before edge 2");

  chk_wake_10: assert property (@(posedge clock) disable iff (!rst_n)
    (frame_active && sck_fall && !sel_rise && edges == `SAP_CNT_W'(`SAP_PDN_HIGH_EDGE - 1))
      |=> !powered_down)
    else $error("no wake after edge 10");

  chk_track_13: assert property (@(posedge clock) disable iff (!rst_n)
    (track_due && frame_active && sck_rise) |=> track_hold)
    else $error("no return to track after edge 13");

  chk_shift_count: assert property (@(posedge clock) disable iff (!rst_n)
    shift_bit |-> edges < `SAP_CNT_W'(`SAP_FRAME_BITS - 1) && !serial_result_oe_n)
    else $error("shift outside drive window");

  chk_start_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    (state == sap_pkg::SAP_IDLE && sel_fall) |=> conv_start ##1 !conv_start)
    else $error("start not a single pulse");

  chk_first_zero: assert property (@(posedge clock) disable iff (!rst_n)
    (state == sap_pkg::SAP_IDLE && sel_fall) |=> ##1 !serial_result_out)
    else $error("first bit not a leading zero");

  chk_stay_up: assert property (@(posedge clock) disable iff (!rst_n)
    (frame_active && sel_rise && !powered_down
      && edges >= `SAP_CNT_W'(`SAP_PDN_HIGH_EDGE)) |=> !powered_down && serial_result_oe_n)
    else $error("late rise powered down");

  chk_sleep_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (sel_rise_pdn || (frame_active && sel_rise && powered_down)) |=> !track_hold)
    else $error("track not held while asleep");

  chk_asleep_rise: assert property (@(posedge clock) disable iff (!rst_n)
    (frame_active && sel_rise && powered_down) |=> powered_down)
    else $error("asleep frame woke on early rise");

  chk_wake_track: assert property (@(posedge clock) disable iff (!rst_n)
    (frame_active && powered_down && !sel_rise && (sck_rise || sck_fall)) |=> track_hold)
    else $error("no track on first edge while waking");
endmodule : sap_ctrl

// ### rtl/sap_defs.svh
// shared constants for the serial converter control block
`ifndef SAP_DEFS_SVH
`define SAP_DEFS_SVH

`define SAP_FRAME_BITS       16
`define SAP_LEAD_ZEROS       4
`define SAP_TRACK_EDGE       13
`define SAP_PDN_LOW_EDGE     2
`define SAP_PDN_HIGH_EDGE    10
`define SAP_CNT_W            5
`define SAP_CLK_PERIOD_PS    5000
`define SAP_DISABLE_DELAY_PS 35000
`define SAP_DISABLE_CYCLES   (`SAP_DISABLE_DELAY_PS / `SAP_CLK_PERIOD_PS)
`define SAP_SYNC_W           2

`endif

// ### rtl/sap_pkg.sv
// types for the serial converter control block
package sap_pkg;
  typedef enum logic [1:0] {
    SAP_IDLE,
    SAP_CONVERT,
    SAP_DONE
  } sap_state_t;
endpackage : sap_pkg

// ### rtl/sap_shift.sv
// result word former and output shifter
`timescale 1ns/1ps
`include "sap_defs.svh"
module sap_shift #(
  parameter int res_bits = 12
) (
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic                        load,
  input  wire logic                        shift,
  input  wire logic [res_bits-1:0]         result,
  output logic                             bit_out
);
  logic [`SAP_FRAME_BITS-1:0] word;

  initial begin
    if (res_bits != 12 && res_bits != 10) $error("res_bits must be 12 or 10");
  end

  // four zeros, result msb first, zero padding for the narrow variant
  function automatic logic [`SAP_FRAME_BITS-1:0] form(input logic [res_bits-1:0] r);
    logic [`SAP_FRAME_BITS-1:0] w;
    w = '0;
    w[`SAP_FRAME_BITS-`SAP_LEAD_ZEROS-1 -: res_bits] = r;
    return w;
  endfunction : form

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      word <= '0;
    end else if (load) begin
      word <= form(result);
    end else if (shift) begin
      word <= {word[`SAP_FRAME_BITS-2:0], 1'b0};
    end
  end

  assign bit_out = word[`SAP_FRAME_BITS-1];
endmodule : sap_shift

// ### rtl/sap_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`include "sap_defs.svh"
module sap_sync #(
  parameter logic init = 1'b0
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      synced
);
  logic meta;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta   <= init;
      synced <= init;
    end else begin
      meta   <= pin;
      synced <= meta;
    end
  end
endmodule : sap_sync

// ### tb/sap_host.sv
// host serial-port model: frame select, serial clock and capture
`timescale 1ns/1ps
module sap_host (
  input  wire logic        clock,
  input  wire logic        data_a,
  input  wire logic        data_b,
  input  wire logic        oe_n,
  input  wire logic        track_hold,
  output logic             select_n,
  output logic             serial_clk,
  output logic [15:0]      word_a,
  output logic [15:0]      word_b,
  output logic [15:0]      word_r,
  output logic [15:0]      th,
  output logic             oe_end,
  output logic             oe_rel
);
  // ----------------------------------------
  // frame driver
  // ----------------------------------------
  // a released line reads inverted, so a capture outside the drive window shows
  // both builds share one select, so their enables move together
  logic line_a;
  logic line_b;
  assign line_a = oe_n ? ~data_a : data_a;
  assign line_b = oe_n ? ~data_b : data_b;

  initial begin
    select_n   = 1'b1;
    serial_clk = 1'b0;
    word_a     = 16'h0;
    word_b     = 16'h0;
    word_r     = 16'h0;
    th         = 16'h0;
    oe_end     = 1'b0;
    oe_rel     = 1'b0;
  end

  // 160 ns serial clock, still between frames
  task automatic frame(input int n);
    select_n <= 1'b0;
    repeat (16) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      word_r     <= {word_r[14:0], line_a};
      serial_clk <= 1'b1;
      repeat (16) @(posedge clock);
      word_a     <= {word_a[14:0], line_a};
      word_b     <= {word_b[14:0], line_b};
      th         <= {th[14:0], track_hold};
      serial_clk <= 1'b0;
      repeat (16) @(posedge clock);
    end
    oe_end   <= oe_n;
    select_n <= 1'b1;
    repeat (7) @(posedge clock);
    oe_rel <= oe_n;
    // gap well over quiet, acquisition and wake time
    repeat (220) @(posedge clock);
  endtask : frame
endmodule : sap_host

// ### tb/sar_adc_serial_power_ctrl_tb_top.sv
// self-checking bench for the serial converter control block
`timescale 1ns/1ps
module sar_adc_serial_power_ctrl_tb_top;
  logic        clock = 1'b0;
  logic        rst_n;
  logic [11:0] res12;
  logic [9:0]  res10;
  logic        sel_n, sclk, out_a, out_b, oe_a, oe_b, th_a, st_a, pd_a, lsb_a;
  logic [15:0] word_a, word_b, word_r, th;
  logic        oe_end, oe_rel;
  int          errors = 0;
  int          checks_done = 0;
  int          starts = 0;
  int          cycles = 0;

  // ----------------------------------------
  // clock, instances, monitors
  // ----------------------------------------
  always #2.5 clock = ~clock;

  sap_ctrl #(.res_bits(12)) sap_ctrl_inst (
    .clock(clock), .rst_n(rst_n), .select_n(sel_n), .serial_clk(sclk),
    .conv_result(res12), .serial_result_out(out_a), .serial_result_oe_n(oe_a),
    .track_hold(th_a), .conv_start(st_a), .powered_down(pd_a), .result_lsb(lsb_a));

  // second build only proves the 10-bit word format
  sap_ctrl #(.res_bits(10)) sap_ctrl_inst_b (
    .clock(clock), .rst_n(rst_n), .select_n(sel_n), .serial_clk(sclk),
    .conv_result(res10), .serial_result_out(out_b), .serial_result_oe_n(oe_b),
    .track_hold(), .conv_start(), .powered_down(), .result_lsb());

  sap_host sap_host_inst (
    .clock(clock), .data_a(out_a), .data_b(out_b), .oe_n(oe_a), .track_hold(th_a),
    .select_n(sel_n), .serial_clk(sclk), .word_a(word_a), .word_b(word_b),
    .word_r(word_r), .th(th), .oe_end(oe_end), .oe_rel(oe_rel));

  always @(posedge clock) begin
    if (st_a === 1'b1) starts <= starts + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // a waking frame tracks from its first serial clock edge on
  task automatic full_frame(input logic [11:0] r12, input logic [9:0] r10, input logic wake);
    int s0;
    s0 = starts;
    res12 <= r12;
    res10 <= r10;
    sap_host_inst.frame(16);
    check("word12", word_a, {4'h0, r12});
    check("word12_rise", word_r, {4'h0, r12});
    check("word10", word_b, {4'h0, r10, 2'b00});
    check("release16", {15'h0, oe_end}, 16'h1);
    check("track13", {13'h0, th[15], th[3:2]}, wake ? 16'h7 : 16'h1);
    check("start", 16'(starts - s0), 16'h1);
    check("lsb", {15'h0, lsb_a}, {15'h0, r12[0]});
    check("powered", {15'h0, pd_a}, 16'h0);
  endtask : full_frame

  // select raised after n falls
  task automatic short_frame(input int n, input logic pd_exp);
    sap_host_inst.frame(n);
    check("pdn", {15'h0, pd_a}, {15'h0, pd_exp});
    check("held", {15'h0, oe_end}, 16'h0);
    check("release", {15'h0, oe_rel}, 16'h1);
    check("hold_after", {15'h0, th_a}, {15'h0, ~pd_exp});
  endtask : short_frame

  task automatic wake_abort();
    short_frame(4, 1'b1);
    check("wake_track", {15'h0, th[3]}, 16'h1);
  endtask : wake_abort

  initial begin
    rst_n = 1'b0;
    res12 = 12'h0;
    res10 = 10'h0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    full_frame(12'ha5d, 10'h2b7, 1'b0);
    short_frame(12, 1'b0);
    short_frame(1, 1'b0);
    short_frame(5, 1'b1);
    wake_abort();
    full_frame(12'hfff, 10'h3ff, 1'b1);
    short_frame(9, 1'b1);
    full_frame(12'h001, 10'h200, 1'b1);
    short_frame(2, 1'b1);
    full_frame(12'h800, 10'h001, 1'b1);
    full_frame(12'h3c6, 10'h1e9, 1'b0);
    conclude();
  end
endmodule : sar_adc_serial_power_ctrl_tb_top
